// file: rtl/lcdcx_exec.sv
// command executor and display data store of a segment lcd driver
// assumes: framing logic presents each command or data byte as a one-cycle strobe
// assumes: drive mode comes from the mode-set logic on the same clock
// assumes: subaddress straps are static pins, synchronised in here
// assumes: ram read address comes from the backplane timing logic
// assumes: one clock; reset synchronous and active high
//
// Notes on behaviour
// - pointer command loads 5-bit value 0..23 into ram address pointer
// - subaddress command stores 3-bit selected subaddress 0..7
// - bank bits pick ram bit 0 or 2 (static), bits 0-1 or 2-3 (1:2)
// - bank select command ignored in 1:3 and 1:4 drive modes
// - blink field 00 off, 01/10/11 select frequency 1, 2, 3
// - blink mode bit 0 normal blinking, 1 alternate bank blinking
// - decoded commands update the operating state, save out-of-range pointers and bank commands in 1:3 or 1:4
// - settings held in status registers, combined for display
// - display data written at pointer locations in storage order
// - pointer byte: C, 00, five pointer bits
// - subaddress byte: C, 1100, three subaddress bits
// - bank byte: C, 11110, input bank bit, output bank bit
// - blink byte: C, 1110, mode bit, two frequency bits
`timescale 1ns/1ns
`default_nettype none
module lcdcx_exec
    import lcdcx_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic CMD_VALID_I,
    input wire logic DATA_VALID_I,
    input wire logic [7:0] BYTE_I,
    input wire logic [1:0] DRIVE_MODE_I,
    input wire logic [2:0] HW_SUBADDR_I,
    input wire logic [4:0] DISP_ADDR_I,
    output logic [4:0] POINTER_O,
    output logic [2:0] SUBADDR_O,
    output logic INPUT_BANK_O,
    output logic OUTPUT_BANK_O,
    output logic [1:0] BLINK_FREQ_O,
    output logic BLINK_ENABLE_O,
    output logic BLINK_ALT_O,
    output logic SELECTED_O,
    output logic [3:0] DISP_DATA_O
);
    ////////////////////////////////////////////////////////////////////
    // decode
    logic [4:0] pointer_reg;
    logic [2:0] subaddr_reg;
    logic in_bank_reg;
    logic out_bank_reg;
    logic [1:0] blink_freq_reg;
    logic blink_alt_reg;
    logic is_ptr;
    logic is_sub;
    logic is_bank;
    logic is_blink;
    logic bank_mode;
    logic ptr_ok;
    logic selected;
    logic ram_we;
    logic [3:0] ram_wdata;
    logic [3:0] ram_wmask;
    logic [4:0] ptr_step;
    logic [2:0] sub_step;
    // synchronised copy of the subaddress straps
    logic [2:0] hw_sub_meta_reg;
    logic [2:0] hw_sub_sync_reg;

    // bit fields of the incoming byte
    // named one by one so each command reads its own field
    logic pointer_bit4, pointer_bit3, pointer_bit2, pointer_bit1, pointer_bit0;
    logic subaddr_bit2, subaddr_bit1, subaddr_bit0;
    logic blink_freq_hi, blink_freq_lo;
    assign {pointer_bit4, pointer_bit3, pointer_bit2, pointer_bit1, pointer_bit0} = BYTE_I[4:0];
    assign {subaddr_bit2, subaddr_bit1, subaddr_bit0} = BYTE_I[2:0];
    assign {blink_freq_hi, blink_freq_lo} = BYTE_I[1:0];

    // opcode match on bits 6..x, bit 7 is the continuation flag
    // mode set (10 in bits 6..5) is decoded elsewhere and matches none
    // each opcode is unique over its own bits, so at most one matches
    assign is_ptr = CMD_VALID_I && (BYTE_I[6:5] == PTR_OP);
    assign is_sub = CMD_VALID_I && (BYTE_I[6:3] == SUB_OP);
    assign is_bank = CMD_VALID_I && (BYTE_I[6:2] == BANK_OP);
    assign is_blink = CMD_VALID_I && (BYTE_I[6:3] == BLINK_OP);
    // bank switching only exists in static and 1:2 drive
    assign bank_mode = (DRIVE_MODE_I == MODE_STATIC) || (DRIVE_MODE_I == MODE_MUX2);

    ////////////////////////////////////////////////////////////////////
    // range test shared by the pointer command and the auto increment;
    // six bits wide so the carry of the increment is seen as well
    // true when the value names one of the ram words
    function automatic logic lcdcx_in_range(input logic [5:0] value);
        lcdcx_in_range = (value <= {1'b0, PTR_MAX});
    endfunction : lcdcx_in_range

    // out-of-range pointer values are dropped, not wrapped
    assign ptr_ok = lcdcx_in_range({1'b0, pointer_bit4, pointer_bit3, pointer_bit2,
                                    pointer_bit1, pointer_bit0});

    // pointer advance, one word per data byte in every drive mode;
    // past the last word it wraps to zero and the next subaddress
    // takes over, so a long stream runs on into the next device
    always_comb begin
        logic [5:0] sum;
        sum = {1'b0, pointer_reg} + 6'h01;
        if (!lcdcx_in_range(sum)) begin
            ptr_step = PTR_RST;
            sub_step = subaddr_reg + 3'h1;
        end else begin
            ptr_step = sum[4:0];
            sub_step = subaddr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strapped subaddress pins sit outside the clock domain; two flops
    // before the compare, no reset, so the straps are settled well
    // before a reset of a few cycles is released
    // a change of strap mid-run shows up two cycles later
    always_ff @(posedge REF_CLK_I) begin
        hw_sub_meta_reg <= HW_SUBADDR_I;
        hw_sub_sync_reg <= hw_sub_meta_reg;
    end

    // pointer and subaddress registers
    // a command wins over data; the two strobes never come together,
    // so the order only matters for a broken framer upstream
    // an out-of-range pointer falls through and leaves both alone
    // the pointer still advances for data meant for another device
    assign selected = (subaddr_reg == hw_sub_sync_reg);
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            pointer_reg <= PTR_RST;
            subaddr_reg <= SUB_RST;
        end else if (is_ptr && ptr_ok) begin
            pointer_reg <= {pointer_bit4, pointer_bit3, pointer_bit2, pointer_bit1,
                            pointer_bit0};
        end else if (is_sub) begin
            subaddr_reg <= {subaddr_bit2, subaddr_bit1, subaddr_bit0};
        end else if (DATA_VALID_I) begin
            pointer_reg <= ptr_step;
            subaddr_reg <= sub_step;
        end
    end

    // bank select status, dropped outside static/1:2
    // stored bits keep their value across a change of drive mode,
    // so a return to static or 1:2 finds the last bank choice
    // a bank command in 1:3 or 1:4 leaves them untouched
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            in_bank_reg <= 1'b0;
            out_bank_reg <= 1'b0;
        end else if (is_bank && bank_mode) begin
            in_bank_reg <= BYTE_I[1];
            out_bank_reg <= BYTE_I[0];
        end
    end

    // blink status
    // frequency and mode are taken as one, from one command byte
    // the blink timer itself sits in the output timing logic
    // a new code takes effect from the next cycle
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            blink_freq_reg <= BLINK_OFF;
            blink_alt_reg <= 1'b0;
        end else if (is_blink) begin
            blink_freq_reg <= {blink_freq_hi, blink_freq_lo};
            blink_alt_reg <= BYTE_I[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ram write: low nibble of byte, masked to the input bank
    // static keeps one bit per bank, 1:2 two bits per bank;
    // 1:3 and 1:4 use the whole word and ignore the bank bit
    // the mask spares the other bank, so two images can share a word
    always_comb begin
        ram_wdata = BYTE_I[3:0];
        ram_wmask = 4'hf;
        if (DRIVE_MODE_I == MODE_STATIC) begin
            ram_wmask = in_bank_reg ? 4'h4 : 4'h1;
            ram_wdata = in_bank_reg ? {1'b0, BYTE_I[0], 2'h0} : {3'h0, BYTE_I[0]};
        end else if (DRIVE_MODE_I == MODE_MUX2) begin
            ram_wmask = in_bank_reg ? 4'hc : 4'h3;
            ram_wdata = in_bank_reg ? {BYTE_I[1:0], 2'h0} : {2'h0, BYTE_I[1:0]};
        end
    end
    // only the addressed device stores; the others just count along
    assign ram_we = DATA_VALID_I && selected;

    // read side free running for the backplane and segment timing,
    // one cycle of latency, address may change every cycle
    lcdcx_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_ram (
        .clk_i(REF_CLK_I),
        .we_i(ram_we),
        .waddr_i(pointer_reg),
        .wdata_i(ram_wdata),
        .wmask_i(ram_wmask),
        .raddr_i(DISP_ADDR_I),
        .rdata_o(DISP_DATA_O)
    );

    ////////////////////////////////////////////////////////////////////
    // status outputs; output bank forced to 0 outside bank modes
    // the gates read the live drive mode, so a change of mode shows
    // at once, without waiting for a new bank or blink command
    // blink enable is a decode of the stored frequency code
    // pointer and subaddress are shown raw for the framing logic
    assign POINTER_O = pointer_reg;
    assign SUBADDR_O = subaddr_reg;
    assign INPUT_BANK_O = in_bank_reg & bank_mode;
    assign OUTPUT_BANK_O = out_bank_reg & bank_mode;
    assign BLINK_FREQ_O = blink_freq_reg;
    assign BLINK_ENABLE_O = (blink_freq_reg != BLINK_OFF);
    assign BLINK_ALT_O = blink_alt_reg & bank_mode;
    assign SELECTED_O = selected;
endmodule : lcdcx_exec
`default_nettype wire

// file: rtl/lcdcx_pkg.sv
// constants for the lcd command executor
// assumes: bytes arrive already framed as command or display data
package lcdcx_pkg;
    // command byte field positions
    localparam int unsigned CONT_BIT = 7;
    localparam logic [1:0] PTR_OP = 2'h0;       // bits 6..5 of pointer cmd
    localparam logic [3:0] SUB_OP = 4'hc;       // bits 6..3 of subaddress cmd
    localparam logic [4:0] BANK_OP = 5'h1e;     // bits 6..2 of bank cmd
    localparam logic [3:0] BLINK_OP = 4'he;     // bits 6..3 of blink cmd
    // ram geometry
    localparam int unsigned RAM_DEPTH = 24;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 4;
    localparam logic [4:0] PTR_MAX = 5'h17;
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [2:0] SUB_RST = 3'h0;
    // drive mode codes (m1 m0)
    localparam logic [1:0] MODE_STATIC = 2'h1;
    localparam logic [1:0] MODE_MUX2 = 2'h2;
    localparam logic [1:0] MODE_MUX3 = 2'h3;
    localparam logic [1:0] MODE_MUX4 = 2'h0;
    localparam logic [1:0] BLINK_OFF = 2'h0;
    typedef enum logic [1:0] {
        LCDCX_CMD_NONE,
        LCDCX_CMD_PTR,
        LCDCX_CMD_SUB,
        LCDCX_CMD_OTHER
    } lcdcx_cmd_type;
endpackage : lcdcx_pkg

// file: rtl/lcdcx_ram.sv
// display ram, 24 words of 4 bits, per-bit write mask
// assumes: one clock, registered read data
`timescale 1ns/1ns
`default_nettype none
module lcdcx_ram #(
    parameter int unsigned DEPTH = 24,
    parameter int unsigned AW = 5,
    parameter int unsigned DW = 4
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [DW-1:0] wmask_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_reg [DEPTH];

    // masked write; only bits set in wmask_i are touched
    always_ff @(posedge clk_i) begin
        if (we_i && (int'(waddr_i) < DEPTH)) begin
            mem_reg[waddr_i] <= (mem_reg[waddr_i] & ~wmask_i) | (wdata_i & wmask_i);
        end
    end

    // registered read, out of range reads zero
    always_ff @(posedge clk_i) begin
        if (int'(raddr_i) < DEPTH) begin
            rdata_o <= mem_reg[raddr_i];
        end else begin
            rdata_o <= '0;
        end
    end
endmodule : lcdcx_ram
`default_nettype wire

// file: dv/lcdcx_exec_props.sv
// port assertions for the lcd command executor
// assumes: bound to lcdcx_exec, one clock
`timescale 1ns/1ns
`default_nettype none
module lcdcx_exec_props
    import lcdcx_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic CMD_VALID_I,
    input wire logic DATA_VALID_I,
    input wire logic [7:0] BYTE_I,
    input wire logic [1:0] DRIVE_MODE_I,
    input wire logic [4:0] POINTER_O,
    input wire logic [2:0] SUBADDR_O,
    input wire logic INPUT_BANK_O,
    input wire logic OUTPUT_BANK_O,
    input wire logic [1:0] BLINK_FREQ_O,
    input wire logic BLINK_ALT_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    // decoded command strobes
    wire logic c_ptr = CMD_VALID_I && BYTE_I[6:5] == PTR_OP;
    wire logic c_bank = CMD_VALID_I && BYTE_I[6:2] == BANK_OP;
    wire logic c_blk = CMD_VALID_I && BYTE_I[6:3] == BLINK_OP;
    wire logic lo_mux = DRIVE_MODE_I == MODE_STATIC || DRIVE_MODE_I == MODE_MUX2;
    ////////////////////////////////////////////////////////////////////////
    property p_ptr; c_ptr && BYTE_I[4:0] <= PTR_MAX |=> POINTER_O == $past(BYTE_I[4:0]); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not loaded");
    property p_oor; c_ptr && BYTE_I[4:0] > PTR_MAX |=> $stable(POINTER_O); endproperty
    a_oor: assert property (p_oor) else $error("bad pointer taken");
    property p_sub; CMD_VALID_I && BYTE_I[6:3] == SUB_OP |=> SUBADDR_O == $past(BYTE_I[2:0]); endproperty
    a_sub: assert property (p_sub) else $error("subaddress not taken");
    property p_bank; c_bank && lo_mux |=> {INPUT_BANK_O, OUTPUT_BANK_O} == $past(BYTE_I[1:0]); endproperty
    a_bank: assert property (p_bank) else $error("bank bits not taken");
    property p_gate; !lo_mux [*2] |-> !INPUT_BANK_O && !OUTPUT_BANK_O && !BLINK_ALT_O; endproperty
    a_gate: assert property (p_gate) else $error("bank active in high mux");
    property p_blk; c_blk |=> BLINK_FREQ_O == $past(BYTE_I[1:0]); endproperty
    a_blk: assert property (p_blk) else $error("blink code not taken");
    property p_alt; c_blk && lo_mux |=> BLINK_ALT_O == $past(BYTE_I[2]); endproperty
    a_alt: assert property (p_alt) else $error("blink mode not taken");
    property p_adv; DATA_VALID_I |=> POINTER_O == ($past(POINTER_O) == PTR_MAX ?
        PTR_RST : $past(POINTER_O) + 5'h01); endproperty
    a_adv: assert property (p_adv) else $error("pointer step wrong");
    property p_wrap; DATA_VALID_I && POINTER_O == PTR_MAX |=>
        SUBADDR_O == $past(SUBADDR_O) + 3'h1; endproperty
    a_wrap: assert property (p_wrap) else $error("subaddress not stepped on wrap");
endmodule : lcdcx_exec_props
bind lcdcx_exec lcdcx_exec_props i_lcdcx_exec_props (.*);
`default_nettype wire

// file: dv/lcdcx_master.sv
// stand-in bus master handing framed command and display bytes
// assumes: called just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module lcdcx_master (
    input wire logic clk_i,
    output logic cmd_o,
    output logic data_o,
    output logic [7:0] byte_o
);
    // quiet at start
    initial begin
        cmd_o = 1'b0;
        data_o = 1'b0;
        byte_o = 8'h00;
    end
    // one byte per edge, strobe kept up for back to back
    task automatic send(input logic is_cmd, input logic [7:0] b);
        cmd_o = is_cmd;
        data_o = !is_cmd;
        byte_o = b;
        @(posedge clk_i);
        #1;
    endtask : send
    // release, stale byte shown inverted
    task automatic idle();
        cmd_o = 1'b0;
        data_o = 1'b0;
        byte_o = ~byte_o;
        @(posedge clk_i);
        #1;
    endtask : idle
endmodule : lcdcx_master
`default_nettype wire

// file: dv/tb_lcdcx_exec.sv
// self-checking bench for the lcd command executor
// assumes: master model drives the byte strobes
`timescale 1ns/1ns
`default_nettype none
module tb_lcdcx_exec
    import lcdcx_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = MODE_MUX4;
    logic [4:0] raddr = 5'h00;
    logic [2:0] hw_sub = 3'h3;
    wire logic cmd, dat, sel;
    wire logic [7:0] b;
    wire logic [3:0] dd;
    wire logic [13:0] st;
    int n_fail = 0;
    int check_count = 0;
    // rows: mode, command byte, status {ptr, sub, banks, freq, en, alt}
    logic [23:0] rows [13] = '{{2'h0, 8'h85, 14'h0a00}, {2'h0, 8'h17, 14'h2e00},
        {2'h0, 8'h98, 14'h2e00}, {2'h0, 8'he5, 14'h2f40}, {2'h1, 8'hfb, 14'h2f70},
        {2'h3, 8'h7a, 14'h2f40}, {2'h2, 8'hfa, 14'h2f60}, {2'h2, 8'hf5, 14'h2f67},
        {2'h2, 8'h72, 14'h2f6a}, {2'h0, 8'h73, 14'h2f4e}, {2'h2, 8'h70, 14'h2f60},
        {2'h0, 8'h79, 14'h2f40}, {2'h2, 8'hc5, 14'h2f60}};
    always #5 clk = ~clk;
    lcdcx_master i_lcdcx_master (.clk_i(clk), .cmd_o(cmd), .data_o(dat), .byte_o(b));
    lcdcx_exec i_lcdcx_exec (.REF_CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(cmd),
        .DATA_VALID_I(dat), .BYTE_I(b), .DRIVE_MODE_I(mode), .HW_SUBADDR_I(hw_sub),
        .DISP_ADDR_I(raddr), .POINTER_O(st[13:9]), .SUBADDR_O(st[8:6]),
        .INPUT_BANK_O(st[5]), .OUTPUT_BANK_O(st[4]), .BLINK_FREQ_O(st[3:2]),
        .BLINK_ENABLE_O(st[1]), .BLINK_ALT_O(st[0]), .SELECTED_O(sel), .DISP_DATA_O(dd));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] s);
        check_count++;
        if (e !== s) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [3:0] e);
        raddr = a;
        @(posedge clk);
        #1;
        chk("ram word", {10'h000, e}, {10'h000, dd});
    endtask : rd
    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("reset state", 14'h0000, st);
        foreach (rows[i]) begin
            mode = rows[i][23:22];
            i_lcdcx_master.send(1'b1, rows[i][21:14]);
            i_lcdcx_master.idle();
            chk("status", rows[i][13:0], st);
        end
        mode = MODE_MUX4;
        i_lcdcx_master.send(1'b1, 8'he3);
        i_lcdcx_master.send(1'b1, 8'h16);
        i_lcdcx_master.send(1'b0, 8'h0a);
        i_lcdcx_master.send(1'b0, 8'h0c);
        i_lcdcx_master.idle();
        chk("wrap", {6'h00, 5'h00, 3'h4}, {6'h00, st[13:6]});
        chk("selected", 14'h0000, {13'h0000, sel});
        rd(5'h16, 4'ha);
        rd(5'h17, 4'hc);
        i_lcdcx_master.send(1'b1, 8'he3);
        chk("selected", 14'h0001, {13'h0000, sel});
        i_lcdcx_master.send(1'b1, 8'h84);
        i_lcdcx_master.send(1'b0, 8'h0f);
        mode = MODE_STATIC;
        i_lcdcx_master.send(1'b1, 8'hfa);
        i_lcdcx_master.send(1'b1, 8'h84);
        i_lcdcx_master.send(1'b0, 8'h00);
        mode = MODE_MUX2;
        i_lcdcx_master.send(1'b1, 8'hf8);
        i_lcdcx_master.send(1'b1, 8'h84);
        i_lcdcx_master.send(1'b0, 8'h02);
        i_lcdcx_master.send(1'b1, 8'he5);
        i_lcdcx_master.send(1'b1, 8'h04);
        mode = MODE_MUX4;
        i_lcdcx_master.send(1'b0, 8'h05);
        i_lcdcx_master.idle();
        chk("pointer", 14'h0005, {9'h000, st[13:9]});
        rd(5'h04, 4'ha);
        hw_sub = 3'h5;
        i_lcdcx_master.idle();
        i_lcdcx_master.idle();
        chk("selected", 14'h0001, {13'h0000, sel});
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        chk("reset again", 14'h0000, st);
        rd(5'h04, 4'ha);
        complete_run();
    end
    // watchdog well past the expected run
    initial begin
        #20000;
        n_fail++;
        complete_run();
    end
endmodule : tb_lcdcx_exec
`default_nettype wire
